// file: shared/dsc_consts.vh
// Constants for the dual synthesizer control latches.
// Included by every design file; definitions only.
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH

// Word geometry
`define DSC_WORD_W 24
`define DSC_WORD_RST 24'h000000

// Latch-select codes, held in the two lowest bits
`define DSC_SEL_HI 1
`define DSC_SEL_LO 0
`define DSC_SEL_IF_REF 2'h0
`define DSC_SEL_IF_FB 2'h1
`define DSC_SEL_RF_REF 2'h2
`define DSC_SEL_RF_FB 2'h3

// Feedback divider words (IF and RF share one layout)
`define DSC_BOOST_BIT 23
`define DSC_SLEEP_BIT 22
`define DSC_PRE_HI 21
`define DSC_PRE_LO 20
`define DSC_B_HI 19
`define DSC_B_LO 8
`define DSC_A_HI 7
`define DSC_A_LO 2

// Reference divider words (IF and RF share one layout)
`define DSC_MUX_HI_BIT 23
`define DSC_CP_HI 22
`define DSC_CP_LO 20
`define DSC_MUX_LO_BIT 19
`define DSC_FLOAT_BIT 18
`define DSC_SENSE_BIT 17
`define DSC_R_HI 15
`define DSC_R_LO 2

// Pump current at full boost
`define DSC_CP_MAX 3'h7

// Mux output modes: {IF ref mux bit, IF ref low mux bit, RF ref low mux bit}
`define DSC_MUX_LOW 3'h0
`define DSC_MUX_IF_LOCK 3'h1
`define DSC_MUX_RF_LOCK 3'h2
`define DSC_MUX_BOTH_LOCK 3'h3
`define DSC_MUX_IF_RESET 3'h4
`define DSC_MUX_RF_RESET 3'h5
`define DSC_MUX_BOTH_RESET 3'h6
`define DSC_MUX_FAST 3'h7

// Pump three-state settle time ahead of a synchronous power-down
`define DSC_PUMP_OFF_NS 100
`define DSC_CLK_MHZ 40

`endif

// file: rtl/dsc_shift.v
// Serial input register: samples shift clock, data and load strobe.
// Assumes all three pins are asynchronous to clk_i and much slower.
`timescale 1ns/100ps
`include "dsc_consts.vh"

module dsc_shift #(
  parameter WORD_W = `DSC_WORD_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire sclk_i,
  input wire serial_input_line_i,
  input wire word_load_strobe_i,
  output reg [WORD_W-1:0] word_o,
  output reg load_o
);

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers
  reg [1:0] sclk_s_q;
  reg [1:0] data_s_q;
  reg [1:0] le_s_q;
  reg sclk_old_q;
  reg le_old_q;
  reg [WORD_W-1:0] shift_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_s_q <= 2'h0;
      data_s_q <= 2'h0;
      le_s_q <= 2'h0;
      sclk_old_q <= 1'b0;
      le_old_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      data_s_q <= {data_s_q[0], serial_input_line_i};
      le_s_q <= {le_s_q[0], word_load_strobe_i};
      sclk_old_q <= sclk_s_q[1];
      le_old_q <= le_s_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift and transfer
  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= {WORD_W{1'b0}};
      word_o <= {WORD_W{1'b0}};
      load_o <= 1'b0;
    end else begin
      load_o <= 1'b0;
      if (sclk_s_q[1] && !sclk_old_q)
        shift_q <= {shift_q[WORD_W-2:0], data_s_q[1]};
      if (le_s_q[1] && !le_old_q) begin
        word_o <= shift_q;
        load_o <= 1'b1;
      end
    end
  end

endmodule

// file: rtl/dsc_pwr.v
// Power-down sequencer for one synthesizer section.
// Assumes sleep and float levels come from latches on the same clock.
`timescale 1ns/100ps
`include "dsc_consts.vh"

module dsc_pwr #(
  parameter [7:0] PUMP_OFF_CYC = 8'h04
) (
  input wire clk_i,
  input wire rst_i,
  input wire sleep_i,
  input wire float_i,
  output wire pump_off_o,
  output wire down_o
);

  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_FLOAT = 3'h2;
  localparam [2:0] ST_DOWN = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_i && float_i) begin
          state_d = ST_DOWN;
        end else if (sleep_i) begin
          state_d = ST_FLOAT;
          cnt_d = PUMP_OFF_CYC;
        end
      end
      ST_FLOAT: begin
        if (!sleep_i) begin
          state_d = ST_RUN;
        end else if (cnt_q <= 8'h01) begin
          state_d = ST_DOWN;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_DOWN: begin
        if (!sleep_i)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
      cnt_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign pump_off_o = (state_q != ST_RUN);
  assign down_o = (state_q == ST_DOWN);

endmodule

// file: rtl/dsc_top.v
// Control latches of a dual IF/RF frequency synthesizer.
// Assumes a serial master on the pins and analog lock flags from
// the loops; every pin is sampled into the clk_i domain.
`timescale 1ns/100ps
`include "dsc_consts.vh"

module dsc_top #(
  parameter WORD_W = `DSC_WORD_W
) (
  input wire clk_i,
  input wire rst_i,
  input wire sclk_i,
  input wire serial_input_line_i,
  input wire word_load_strobe_i,
  input wire if_locked_i,
  input wire rf_locked_i,
  input wire if_pd_pulse_i,
  input wire rf_pd_pulse_i,
  output reg [13:0] if_reference_divider_o,
  output reg [5:0] if_swallow_o,
  output reg [11:0] if_prog_o,
  output reg [1:0] if_prescaler_o,
  output reg [13:0] rf_reference_divider_o,
  output reg [5:0] rf_swallow_o,
  output reg [11:0] rf_prog_o,
  output reg [1:0] rf_prescaler_o,
  output reg if_sense_o,
  output reg rf_sense_o,
  output reg [2:0] if_pump_current_o,
  output reg [2:0] rf_pump_current_o,
  output reg if_pump_hiz_o,
  output reg rf_pump_hiz_o,
  output reg if_div_reset_o,
  output reg rf_div_reset_o,
  output reg if_div_load_o,
  output reg rf_div_load_o,
  output reg if_input_hiz_o,
  output reg rf_input_hiz_o,
  output reg ref_osc_en_o,
  output reg outputs_active_o,
  output reg mux_output_pin_o,
  output reg mux_output_pin_oe_o,
  output reg damping_switch_pin_o,
  output reg damping_switch_pin_oe_o
);

  // Pump settle time rounded up to whole clock cycles
  localparam [31:0] PUMP_OFF_FULL =
    (`DSC_PUMP_OFF_NS * `DSC_CLK_MHZ + 999) / 1000;
  localparam [7:0] PUMP_OFF_CYC = PUMP_OFF_FULL[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Serial input register

  wire [WORD_W-1:0] word;
  wire load;
  wire [1:0] sel;

  // Keeps running regardless of any sleep state
  dsc_shift #(
    .WORD_W(WORD_W)
  ) u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .serial_input_line_i(serial_input_line_i),
    .word_load_strobe_i(word_load_strobe_i),
    .word_o(word),
    .load_o(load)
  );

  assign sel = word[`DSC_SEL_HI:`DSC_SEL_LO];

  ////////////////////////////////////////////////////////////////////////
  // Four latches

  reg [WORD_W-1:0] if_ref_word_q;
  reg [WORD_W-1:0] if_fb_word_q;
  reg [WORD_W-1:0] rf_ref_word_q;
  reg [WORD_W-1:0] rf_feedback_divider_word_q;
  reg [3:0] written_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      if_ref_word_q <= `DSC_WORD_RST;
      if_fb_word_q <= `DSC_WORD_RST;
      rf_ref_word_q <= `DSC_WORD_RST;
      rf_feedback_divider_word_q <= `DSC_WORD_RST;
      written_q <= 4'h0;
    end else if (load) begin
      case (sel)
        `DSC_SEL_IF_REF: begin
          if_ref_word_q <= word;
          written_q[0] <= 1'b1;
        end
        `DSC_SEL_IF_FB: begin
          if_fb_word_q <= word;
          written_q[1] <= 1'b1;
        end
        `DSC_SEL_RF_REF: begin
          rf_ref_word_q <= word;
          written_q[2] <= 1'b1;
        end
        `DSC_SEL_RF_FB: begin
          rf_feedback_divider_word_q <= word;
          written_q[3] <= 1'b1;
        end
        default: written_q <= written_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field views

  wire if_sleep_bit;
  wire rf_sleep_bit;
  wire if_pump_float_bit;
  wire rf_pump_float_bit;
  wire if_pump_boost_bit;
  wire rf_pump_boost_bit;
  wire [2:0] mux_mode;

  assign if_sleep_bit = if_fb_word_q[`DSC_SLEEP_BIT];
  assign rf_sleep_bit = rf_feedback_divider_word_q[`DSC_SLEEP_BIT];
  assign if_pump_float_bit = if_ref_word_q[`DSC_FLOAT_BIT];
  assign rf_pump_float_bit = rf_ref_word_q[`DSC_FLOAT_BIT];
  assign if_pump_boost_bit = if_fb_word_q[`DSC_BOOST_BIT];
  assign rf_pump_boost_bit = rf_feedback_divider_word_q[`DSC_BOOST_BIT];
  assign mux_mode = {if_ref_word_q[`DSC_MUX_HI_BIT],
                     if_ref_word_q[`DSC_MUX_LO_BIT],
                     rf_ref_word_q[`DSC_MUX_LO_BIT]};

  // Maximum current while boosted, else the latched setting
  function [2:0] pump_current;
    input boost;
    input [2:0] field;
    begin
      pump_current = boost ? `DSC_CP_MAX : field;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Power-down sequencers

  wire if_pump_off;
  wire rf_pump_off;
  wire if_down;
  wire rf_down;

  dsc_pwr #(
    .PUMP_OFF_CYC(PUMP_OFF_CYC)
  ) u_if_pwr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sleep_i(if_sleep_bit),
    .float_i(if_pump_float_bit),
    .pump_off_o(if_pump_off),
    .down_o(if_down)
  );

  dsc_pwr #(
    .PUMP_OFF_CYC(PUMP_OFF_CYC)
  ) u_rf_pwr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sleep_i(rf_sleep_bit),
    .float_i(rf_pump_float_bit),
    .pump_off_o(rf_pump_off),
    .down_o(rf_down)
  );

  ////////////////////////////////////////////////////////////////////////
  // Lock flag synchronisers

  reg [1:0] if_lock_s_q;
  reg [1:0] rf_lock_s_q;
  reg [1:0] if_pulse_s_q;
  reg [1:0] rf_pulse_s_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      if_lock_s_q <= 2'h0;
      rf_lock_s_q <= 2'h0;
      if_pulse_s_q <= 2'h0;
      rf_pulse_s_q <= 2'h0;
    end else begin
      if_lock_s_q <= {if_lock_s_q[0], if_locked_i};
      rf_lock_s_q <= {rf_lock_s_q[0], rf_locked_i};
      if_pulse_s_q <= {if_pulse_s_q[0], if_pd_pulse_i};
      rf_pulse_s_q <= {rf_pulse_s_q[0], rf_pd_pulse_i};
    end
  end

  wire if_lock_ind;
  wire rf_lock_ind;
  assign if_lock_ind = if_lock_s_q[1] & ~if_pulse_s_q[1];
  assign rf_lock_ind = rf_lock_s_q[1] & ~rf_pulse_s_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Mode decode

  reg if_cnt_rst;
  reg rf_cnt_rst;
  reg mux_d;
  reg mux_oe_d;

  always @* begin
    if_cnt_rst = 1'b0;
    rf_cnt_rst = 1'b0;
    mux_d = 1'b0;
    mux_oe_d = 1'b1;
    case (mux_mode)
      `DSC_MUX_LOW: mux_d = 1'b0;
      `DSC_MUX_IF_LOCK: mux_d = if_lock_ind;
      `DSC_MUX_RF_LOCK: mux_d = rf_lock_ind;
      `DSC_MUX_BOTH_LOCK: mux_d = if_lock_ind & rf_lock_ind;
      `DSC_MUX_IF_RESET: if_cnt_rst = 1'b1;
      `DSC_MUX_RF_RESET: rf_cnt_rst = 1'b1;
      `DSC_MUX_BOTH_RESET: begin
        if_cnt_rst = 1'b1;
        rf_cnt_rst = 1'b1;
      end
      `DSC_MUX_FAST: begin
        mux_d = 1'b0;
        mux_oe_d = rf_pump_boost_bit;
      end
      default: mux_d = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always @(posedge clk_i) begin
    if (rst_i) begin
      if_reference_divider_o <= 14'h0000;
      if_swallow_o <= 6'h00;
      if_prog_o <= 12'h000;
      if_prescaler_o <= 2'h0;
      rf_reference_divider_o <= 14'h0000;
      rf_swallow_o <= 6'h00;
      rf_prog_o <= 12'h000;
      rf_prescaler_o <= 2'h0;
      if_sense_o <= 1'b0;
      rf_sense_o <= 1'b0;
      if_pump_current_o <= 3'h0;
      rf_pump_current_o <= 3'h0;
      if_pump_hiz_o <= 1'b1;
      rf_pump_hiz_o <= 1'b1;
      if_div_reset_o <= 1'b0;
      rf_div_reset_o <= 1'b0;
      if_div_load_o <= 1'b0;
      rf_div_load_o <= 1'b0;
      if_input_hiz_o <= 1'b0;
      rf_input_hiz_o <= 1'b0;
      ref_osc_en_o <= 1'b1;
      outputs_active_o <= 1'b0;
      mux_output_pin_o <= 1'b0;
      mux_output_pin_oe_o <= 1'b0;
      damping_switch_pin_o <= 1'b0;
      damping_switch_pin_oe_o <= 1'b0;
    end else begin
      if_reference_divider_o <= if_ref_word_q[`DSC_R_HI:`DSC_R_LO];
      if_swallow_o <= if_fb_word_q[`DSC_A_HI:`DSC_A_LO];
      if_prog_o <= if_fb_word_q[`DSC_B_HI:`DSC_B_LO];
      if_prescaler_o <= if_fb_word_q[`DSC_PRE_HI:`DSC_PRE_LO];
      rf_reference_divider_o <= rf_ref_word_q[`DSC_R_HI:`DSC_R_LO];
      rf_swallow_o <= rf_feedback_divider_word_q[`DSC_A_HI:`DSC_A_LO];
      rf_prog_o <= rf_feedback_divider_word_q[`DSC_B_HI:`DSC_B_LO];
      rf_prescaler_o <=
        rf_feedback_divider_word_q[`DSC_PRE_HI:`DSC_PRE_LO];
      if_sense_o <= if_ref_word_q[`DSC_SENSE_BIT];
      rf_sense_o <= rf_ref_word_q[`DSC_SENSE_BIT];
      if_pump_current_o <= pump_current(if_pump_boost_bit,
        if_ref_word_q[`DSC_CP_HI:`DSC_CP_LO]);
      rf_pump_current_o <= pump_current(rf_pump_boost_bit,
        rf_ref_word_q[`DSC_CP_HI:`DSC_CP_LO]);
      // Pump stays floated until every latch holds a word
      if_pump_hiz_o <= if_pump_float_bit | if_cnt_rst | if_pump_off |
                       ~(&written_q);
      rf_pump_hiz_o <= rf_pump_float_bit | rf_cnt_rst | rf_pump_off |
                       ~(&written_q);
      // Each divider has its own reset line, both driven from the one shared mux mode decode
      if_div_reset_o <= if_cnt_rst;
      rf_div_reset_o <= rf_cnt_rst;
      if_div_load_o <= if_down;
      rf_div_load_o <= rf_down;
      if_input_hiz_o <= if_down;
      rf_input_hiz_o <= rf_down;
      ref_osc_en_o <= ~(if_sleep_bit & rf_sleep_bit);
      outputs_active_o <= &written_q;
      mux_output_pin_o <= mux_d;
      mux_output_pin_oe_o <= mux_oe_d;
      damping_switch_pin_o <= 1'b0;
      damping_switch_pin_oe_o <= rf_pump_boost_bit;
    end
  end

endmodule

// file: sim/dsc_host_model.sv
// Serial host model: shifts 24-bit words, then pulses the load strobe.
// Assumes clk_i is the 40 MHz bench clock; shift clock period 200 ns.
`timescale 1ns/100ps

module dsc_host_model (
  input wire clk_i,
  output logic sclk_o,
  output logic serial_input_line_o,
  output logic load_o
);
  initial begin
    sclk_o = 1'h0;
    serial_input_line_o = 1'h0;
    load_o = 1'h0;
  end

  // Shift clock idles low; data shows the inverse once a frame ends
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serial_input_line_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'h1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'h0;
    end
    serial_input_line_o = ~w[0];
    repeat (4) @(negedge clk_i);
    load_o = 1'h1;
    repeat (16) @(negedge clk_i);
    load_o = 1'h0;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// file: sim/dsc_top_assertions.sv
// Port-level checker for the dual synthesizer control latches.
// Assumes it is bound into dsc_top and sees only its ports.
`timescale 1ns/100ps

module dsc_checker (
  input wire clk_i,
  input wire rst_i,
  input wire word_load_strobe_i,
  input wire [11:0] rf_prog_o,
  input wire [2:0] rf_pump_current_o,
  input wire if_pump_hiz_o,
  input wire rf_pump_hiz_o,
  input wire if_div_reset_o,
  input wire rf_div_reset_o,
  input wire if_div_load_o,
  input wire rf_div_load_o,
  input wire if_input_hiz_o,
  input wire rf_input_hiz_o,
  input wire ref_osc_en_o,
  input wire outputs_active_o,
  input wire damping_switch_pin_o,
  input wire damping_switch_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Cycles since the strobe pin was last seen rising
  logic [3:0] since_q;
  logic le_q;
  always @(posedge clk_i) begin
    le_q <= word_load_strobe_i;
    if (rst_i)
      since_q <= 4'hf;
    else if (word_load_strobe_i && !le_q)
      since_q <= 4'h0;
    else if (since_q != 4'hf)
      since_q <= since_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////
  a_latch_after_load: assert property ($changed(rf_prog_o) |->
    since_q <= 4'h9) else $error("divider changed without a load");
  a_osc_both_down: assert property ($fell(ref_osc_en_o) |->
    ##[0:8] (if_div_load_o && rf_div_load_o))
    else $error("oscillator off with a section awake");
  a_if_float_first: assert property ($rose(if_div_load_o) |->
    $past(if_pump_hiz_o)) else $error("IF down before pump floated");
  a_rf_float_first: assert property ($rose(rf_div_load_o) |->
    $past(rf_pump_hiz_o)) else $error("RF down before pump floated");
  a_down_input_hiz: assert property ((if_div_load_o == if_input_hiz_o)
    && (rf_div_load_o == rf_input_hiz_o))
    else $error("load state and input stage disagree");
  a_reset_pump_float: assert property ((if_div_reset_o [*2]) |->
    if_pump_hiz_o) else $error("IF pump driven in counter reset");
  a_rf_reset_float: assert property ((rf_div_reset_o [*2]) |->
    rf_pump_hiz_o) else $error("RF pump driven in counter reset");
  a_boost_max: assert property (damping_switch_pin_oe_o |->
    rf_pump_current_o == 3'h7) else $error("boost without full current");
  a_damp_low: assert property (damping_switch_pin_oe_o |->
    !damping_switch_pin_o) else $error("damping switch not grounded");
  a_idle_float: assert property (!outputs_active_o |->
    if_pump_hiz_o && rf_pump_hiz_o) else $error("pump driven before setup");
  a_active_stays: assert property (outputs_active_o |=>
    outputs_active_o) else $error("outputs went inactive");

  c_boost: cover property ($rose(damping_switch_pin_oe_o));
  c_if_down: cover property ($rose(if_div_load_o));
  c_osc_off: cover property ($fell(ref_osc_en_o));
endmodule

bind dsc_top dsc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .word_load_strobe_i(word_load_strobe_i), .rf_prog_o(rf_prog_o),
  .rf_pump_current_o(rf_pump_current_o), .if_pump_hiz_o(if_pump_hiz_o),
  .rf_pump_hiz_o(rf_pump_hiz_o), .if_div_reset_o(if_div_reset_o),
  .rf_div_reset_o(rf_div_reset_o), .if_div_load_o(if_div_load_o),
  .rf_div_load_o(rf_div_load_o), .if_input_hiz_o(if_input_hiz_o),
  .rf_input_hiz_o(rf_input_hiz_o), .ref_osc_en_o(ref_osc_en_o),
  .outputs_active_o(outputs_active_o),
  .damping_switch_pin_o(damping_switch_pin_o),
  .damping_switch_pin_oe_o(damping_switch_pin_oe_o));

// file: sim/tb.sv
// Self-checking bench for the dual synthesizer control latches.
// Assumes the host model drives the serial pins; lock flags from here.
`timescale 1ns/100ps

module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic il = 1'h0;
  logic rl = 1'h0;
  logic ip = 1'h0;
  logic rp = 1'h0;
  wire sclk, serial_input_line, le, if_sense, rf_sense, if_hiz, rf_hiz, if_rst, rf_rst;
  wire if_load, rf_load, if_ihz, rf_ihz, osc_en, active;
  wire mux, mux_oe, damp, damp_oe;
  wire [13:0] if_r, rf_r;
  wire [11:0] if_b, rf_b;
  wire [5:0] if_a, rf_a;
  wire [2:0] if_cp, rf_cp;
  wire [1:0] if_pre, rf_pre;
  int failures = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;

  dsc_host_model host (.clk_i(clk), .sclk_o(sclk), .serial_input_line_o(serial_input_line),
    .load_o(le));
  dsc_top dut (.clk_i(clk), .rst_i(rst), .sclk_i(sclk),
    .serial_input_line_i(serial_input_line), .word_load_strobe_i(le),
    .if_locked_i(il), .rf_locked_i(rl), .if_pd_pulse_i(ip),
    .rf_pd_pulse_i(rp), .if_reference_divider_o(if_r),
    .if_swallow_o(if_a), .if_prog_o(if_b), .if_prescaler_o(if_pre),
    .rf_reference_divider_o(rf_r), .rf_swallow_o(rf_a), .rf_prog_o(rf_b),
    .rf_prescaler_o(rf_pre), .if_sense_o(if_sense), .rf_sense_o(rf_sense),
    .if_pump_current_o(if_cp), .rf_pump_current_o(rf_cp),
    .if_pump_hiz_o(if_hiz), .rf_pump_hiz_o(rf_hiz),
    .if_div_reset_o(if_rst), .rf_div_reset_o(rf_rst),
    .if_div_load_o(if_load), .rf_div_load_o(rf_load),
    .if_input_hiz_o(if_ihz), .rf_input_hiz_o(rf_ihz),
    .ref_osc_en_o(osc_en), .outputs_active_o(active),
    .mux_output_pin_o(mux), .mux_output_pin_oe_o(mux_oe),
    .damping_switch_pin_o(damp), .damping_switch_pin_oe_o(damp_oe));

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // IF words: sense 1, pump code 5; RF words: sense 0, pump code 3
  task automatic wr_ref(input logic [1:0] sel, input logic hi, lo, fl,
    input logic [13:0] r);
    host.send({hi, (sel[1] ? 3'h3 : 3'h5), lo, fl, ~sel[1], 1'h0, r, sel});
  endtask

  task automatic wr_fb(input logic [1:0] sel, input logic boost, sleep);
    host.send({boost, sleep, (sel[1] ? 2'h1 : 2'h2),
      (sel[1] ? 12'hf0f : 12'h5a3), (sel[1] ? 6'h3f : 6'h2d), sel});
  endtask

  task automatic set_mode(input logic [2:0] m);
    wr_ref(2'h0, m[2], m[1], 1'h0, 14'h1abc);
    wr_ref(2'h2, 1'h0, m[0], 1'h0, 14'h2c35);
  endtask

  function automatic logic mux_exp(input logic [2:0] m, input logic a, b);
    mux_exp = (m == 3'h1 & a) | (m == 3'h2 & b) | (m == 3'h3 & a & b);
  endfunction

  initial begin
    #1000000;
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] md;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    check("if pump hiz", if_hiz, 1'h1);
    check("osc en", osc_en, 1'h1);
    wr_ref(2'h0, 1'h0, 1'h0, 1'h0, 14'h1abc);
    check("if r", if_r, 14'h1abc);
    check("if cp", if_cp, 3'h5);
    check("if sense", if_sense, 1'h1);
    wr_fb(2'h1, 1'h0, 1'h0);
    check("if b", if_b, 12'h5a3);
    check("if a", if_a, 6'h2d);
    check("if pre", if_pre, 2'h2);
    wr_ref(2'h2, 1'h0, 1'h0, 1'h0, 14'h2c35);
    check("rf r", rf_r, 14'h2c35);
    check("rf cp", rf_cp, 3'h3);
    check("rf sense", rf_sense, 1'h0);
    check("active", active, 1'h0);
    wr_fb(2'h3, 1'h0, 1'h0);
    check("rf b", rf_b, 12'hf0f);
    check("rf a", rf_a, 6'h3f);
    check("rf pre", rf_pre, 2'h1);
    check("active", active, 1'h1);
    check("if pump hiz", if_hiz, 1'h0);
    wr_fb(2'h1, 1'h1, 1'h0);
    wr_fb(2'h3, 1'h1, 1'h0);
    check("if cp", if_cp, 3'h7);
    check("rf cp", rf_cp, 3'h7);
    check("damp oe", damp_oe, 1'h1);
    check("damp", damp, 1'h0);
    wr_fb(2'h1, 1'h0, 1'h0);
    wr_fb(2'h3, 1'h0, 1'h0);
    check("if cp", if_cp, 3'h5);
    check("rf cp", rf_cp, 3'h3);
    check("damp oe", damp_oe, 1'h0);
    il = 1'h1;
    for (int m = 0; m < 8; m++) begin
      md = 3'(m);
      set_mode(md);
      check("mux", mux, mux_exp(md, 1'h1, 1'h0));
      check("mux oe", mux_oe, md != 3'h7);
      check("if reset", if_rst, md == 3'h4 || md == 3'h6);
      check("rf reset", rf_rst, md == 3'h5 || md == 3'h6);
      check("if pump hiz", if_hiz, md == 3'h4 || md == 3'h6);
      check("rf pump hiz", rf_hiz, md == 3'h5 || md == 3'h6);
      rl = 1'h1;
      repeat (6) @(negedge clk);
      check("mux", mux, mux_exp(md, 1'h1, 1'h1));
      ip = 1'h1;
      repeat (6) @(negedge clk);
      check("mux notch", mux, mux_exp(md, 1'h0, 1'h1));
      ip = 1'h0;
      rp = 1'h1;
      repeat (6) @(negedge clk);
      check("mux rf notch", mux, mux_exp(md, 1'h1, 1'h0));
      rp = 1'h0;
      rl = 1'h0;
    end
    wr_fb(2'h3, 1'h1, 1'h0);
    check("mux oe", mux_oe, 1'h1);
    check("mux", mux, 1'h0);
    wr_fb(2'h3, 1'h0, 1'h0);
    set_mode(3'h0);
    wr_fb(2'h1, 1'h0, 1'h1);
    check("if load", if_load, 1'h1);
    check("if in hiz", if_ihz, 1'h1);
    check("if pump hiz", if_hiz, 1'h1);
    check("osc en", osc_en, 1'h1);
    wr_ref(2'h2, 1'h0, 1'h0, 1'h1, 14'h2c35);
    check("rf pump hiz", rf_hiz, 1'h1);
    wr_fb(2'h3, 1'h0, 1'h1);
    check("rf load", rf_load, 1'h1);
    check("rf in hiz", rf_ihz, 1'h1);
    check("osc en", osc_en, 1'h0);
    wr_ref(2'h2, 1'h0, 1'h0, 1'h1, 14'h0777);
    check("rf r", rf_r, 14'h0777);
    wr_fb(2'h1, 1'h0, 1'h0);
    check("if load", if_load, 1'h0);
    check("if in hiz", if_ihz, 1'h0);
    check("osc en", osc_en, 1'h1);
    wr_ref(2'h0, 1'h0, 1'h0, 1'h1, 14'h1abc);
    wr_fb(2'h1, 1'h0, 1'h1);
    check("if load", if_load, 1'h1);
    stop_test();
  end
endmodule
